// *** rtl/secl_pkg.sv ***
package secl_pkg;

    // clock and bus rates
    localparam int unsigned MCLK_HZ = 40_000_000;
    localparam int unsigned SLOW_HZ = 100_000;
    localparam int unsigned FAST_HZ = 400_000;
    // prescaler holds MCLK cycles per quarter bit, minus one
    localparam logic [7:0] PRESC_SLOW = 8'(MCLK_HZ / (4 * SLOW_HZ) - 1);
    localparam logic [7:0] PRESC_FAST = 8'(MCLK_HZ / (4 * FAST_HZ) - 1);

    // strap synchroniser depth before straps are trusted
    localparam logic [1:0] SYNC_CYCLES = 2'h2;
    // one bit per operating mode; set bits load from the eeprom
    localparam logic [15:0] EE_MODE_MASK = 16'hAAAA;
    // fixed upper bits 6:4 of the eeprom slave address
    localparam logic [2:0] SLAVE_FIXED = 3'h5;

    // register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_SWITCH_CONTROL_REGISTER = 8'h08;
    // field positions
    localparam int unsigned CTRL_SKIP_BIT = 8;
    localparam int unsigned STAT_DONE_BIT = 0;
    localparam int unsigned STAT_CKS_BIT = 1;
    localparam int unsigned STAT_ROLL_BIT = 2;
    localparam int unsigned STAT_BLANK_BIT = 3;
    localparam int unsigned SWITCH_CONTROL_REGISTER_HALT_BIT = 0;
    // values after reset
    localparam logic [3:0] STAT_RESET = 4'h0;
    localparam logic SKIP_RESET = 1'b0;
    localparam logic HALT_RESET = 1'b0;

    // block type codes in byte 0 bits 7:6
    localparam logic [1:0] TYPE_SINGLE = 2'h0;
    localparam logic [1:0] TYPE_SEQ = 2'h1;
    localparam logic [1:0] TYPE_BAD = 2'h2;
    localparam logic [1:0] TYPE_DONE = 2'h3;

    localparam logic [7:0] CKSUM_GOOD = 8'hFF;
    localparam logic [7:0] BLANK_BYTE = 8'hFF;
    localparam logic [15:0] BLANK_LAST = 16'h00FF;
    localparam logic [15:0] ADDR_LAST = 16'hFFFF;

    typedef enum logic [3:0] {
        S_SYNC = 4'h0,
        S_IDLE = 4'h1,
        S_TYPE = 4'h2,
        S_AL = 4'h3,
        S_AH = 4'h4,
        S_CL = 4'h5,
        S_CH = 4'h6,
        S_DATA = 4'h7,
        S_CKSUM = 4'h8,
        S_BLANK = 4'h9
    } secl_state_type;

endpackage : secl_pkg

// *** rtl/secl_loader.sv ***
// Functional notes
// RULE1 - loader is sole master, one request outstanding
// RULE2 - slow strap picks 100 KHz else 400 KHz
// RULE3 - load only in eeprom operating modes
// RULE4 - slave address straps 4:1, then 1,0,1
// RULE5 - read from byte zero until done/wrap
// RULE6 - wrap past 0xFFFF aborts, rollover and halt
// RULE7 - first 256 bytes 0xFF: blank, no halt
// RULE8 - block addresses are dword addresses
// RULE9 - each write is a whole 32-bit dword
// RULE10 - type 0x0: seven bytes, one dword
// RULE11 - single block byte layout, data LSB first
// RULE12 - byte address is dword address times four
// RULE13 - type 0x1: address, count, count dwords
// RULE14 - sequential data to consecutive dword addresses
// RULE15 - type 0x3 ends load, carries checksum
// RULE16 - byte sum must be 0xFF unless skipped
// RULE17 - type 0x2 aborts with checksum error, halt
// RULE18 - load complete flag on any ending
// RULE19 - write only after all four data bytes
// RULE20 - hold init until loader reaches idle
`timescale 1ns/1ps
`default_nettype none

module secl_loader (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic MASTER_SLOW_MODE_STRAP,
    input wire logic [3:0] SWITCH_OPERATING_MODE_STRAP,
    input wire logic [3:0] EEPROM_ADDRESS_STRAPS,
    output logic EE_REQ,
    output logic [6:0] EE_SLAVE_ADDR,
    output logic [15:0] EE_BYTE_ADDR,
    input wire logic EE_ACK,
    input wire logic [7:0] EE_DATA,
    output logic REG_WR,
    output logic [17:0] REG_ADDR,
    output logic [31:0] REG_WDATA,
    output logic INIT_HOLD,
    output logic [7:0] MASTER_CLOCK_PRESCALER
);

    function automatic logic is_fetch(input secl_pkg::secl_state_type s);
        is_fetch = (s != secl_pkg::S_SYNC) && (s != secl_pkg::S_IDLE);
    endfunction : is_fetch

    function automatic logic uses_ee(input logic [3:0] mode);
        uses_ee = secl_pkg::EE_MODE_MASK[mode];
    endfunction : uses_ee

    ////////////////////////////////////////////////////////////////////
    // strap synchroniser: stage one feeds stage two only
    logic [8:0] strap_s1;
    logic [8:0] strap_s2;
    logic slow_sync;
    logic [3:0] mode_sync;
    logic [3:0] eaddr_sync;

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            strap_s1 <= 9'h000;
            strap_s2 <= 9'h000;
        end else begin
            strap_s1 <= {MASTER_SLOW_MODE_STRAP, SWITCH_OPERATING_MODE_STRAP,
                         EEPROM_ADDRESS_STRAPS};
            strap_s2 <= strap_s1;
        end
    end

    assign slow_sync = strap_s2[8];
    assign mode_sync = strap_s2[7:4];
    assign eaddr_sync = strap_s2[3:0];

    ////////////////////////////////////////////////////////////////////
    // loader
    secl_pkg::secl_state_type state, next_state;
    logic [1:0] sync_cnt, next_sync_cnt;
    logic [15:0] addr, next_addr;
    logic [15:0] dw, next_dw;
    logic [15:0] cnt, next_cnt;
    logic [23:0] data, next_data;
    logic [1:0] bidx, next_bidx;
    logic seq, next_seq;
    logic [7:0] cksum, next_cksum;
    logic [6:0] slave, next_slave;
    logic reg_wr, next_reg_wr;
    logic [17:0] reg_addr, next_reg_addr;
    logic [31:0] reg_wdata, next_reg_wdata;
    logic ee_req, next_ee_req;
    logic init_hold, next_init_hold;
    logic ev_strap, ev_done, ev_cks, ev_roll, ev_blank, ev_halt;
    logic skip;
    logic [7:0] sum;

    always_comb begin
        next_state = state;
        next_sync_cnt = sync_cnt;
        next_addr = addr;
        next_dw = dw;
        next_cnt = cnt;
        next_data = data;
        next_bidx = bidx;
        next_seq = seq;
        next_cksum = cksum;
        next_slave = slave;
        next_reg_wr = 1'b0;
        next_reg_addr = reg_addr;
        next_reg_wdata = reg_wdata;
        ev_strap = 1'b0;
        ev_cks = 1'b0;
        ev_roll = 1'b0;
        ev_blank = 1'b0;
        ev_halt = 1'b0;
        sum = 8'(cksum + EE_DATA);
        if (state == secl_pkg::S_SYNC) begin
            next_sync_cnt = 2'(sync_cnt + 2'h1);
            if (sync_cnt == secl_pkg::SYNC_CYCLES) begin
                ev_strap = 1'b1;
                // RULE4 slave address build
                next_slave = {secl_pkg::SLAVE_FIXED, eaddr_sync};
                // RULE3 mode gates loading
                if (uses_ee(mode_sync)) begin
                    // RULE5 start at byte zero
                    next_state = secl_pkg::S_TYPE;
                    next_addr = 16'h0000;
                    next_cksum = 8'h00;
                end else begin
                    next_state = secl_pkg::S_IDLE;
                end
            end
        end else if (is_fetch(state) && EE_ACK) begin
            next_addr = 16'(addr + 16'h0001);
            next_cksum = sum;
            case (state)
                secl_pkg::S_TYPE: begin
                    // RULE7 leading 0xFF starts blank check
                    if (addr == 16'h0000
                        && EE_DATA == secl_pkg::BLANK_BYTE) begin
                        next_state = secl_pkg::S_BLANK;
                    end else begin
                        case (EE_DATA[7:6])
                            // RULE10 single dword block
                            secl_pkg::TYPE_SINGLE: begin
                                next_seq = 1'b0;
                                next_state = secl_pkg::S_AL;
                            end
                            // RULE13 sequential block
                            secl_pkg::TYPE_SEQ: begin
                                next_seq = 1'b1;
                                next_state = secl_pkg::S_AL;
                            end
                            // RULE15 done block, checksum follows
                            secl_pkg::TYPE_DONE: begin
                                next_state = secl_pkg::S_CKSUM;
                            end
                            // RULE17 invalid type aborts
                            default: begin
                                ev_cks = 1'b1;
                                ev_halt = 1'b1;
                                next_state = secl_pkg::S_IDLE;
                            end
                        endcase
                    end
                end
                // RULE8 dword address low then high
                secl_pkg::S_AL: begin
                    next_dw = {dw[15:8], EE_DATA};
                    next_state = secl_pkg::S_AH;
                end
                secl_pkg::S_AH: begin
                    next_dw = {EE_DATA, dw[7:0]};
                    next_bidx = 2'h0;
                    next_state = seq ? secl_pkg::S_CL : secl_pkg::S_DATA;
                end
                // RULE13 count, low byte first
                secl_pkg::S_CL: begin
                    next_cnt = {cnt[15:8], EE_DATA};
                    next_state = secl_pkg::S_CH;
                end
                secl_pkg::S_CH: begin
                    next_cnt = {EE_DATA, cnt[7:0]};
                    if ({EE_DATA, cnt[7:0]} == 16'h0000) begin
                        next_state = secl_pkg::S_TYPE;
                    end else begin
                        next_state = secl_pkg::S_DATA;
                    end
                end
                secl_pkg::S_DATA: begin
                    // RULE11 data least significant byte first
                    next_data = {EE_DATA, data[23:8]};
                    next_bidx = 2'(bidx + 2'h1);
                    if (bidx == 2'h3) begin
                        // RULE19 write after fourth byte
                        // RULE9 whole dword written
                        next_reg_wr = 1'b1;
                        next_reg_wdata = {EE_DATA, data};
                        // RULE12 byte address from dword address
                        next_reg_addr = {dw, 2'b00};
                        // RULE14 consecutive dword addresses
                        next_dw = 16'(dw + 16'h0001);
                        next_cnt = 16'(cnt - 16'h0001);
                        if (!seq || cnt == 16'h0001) begin
                            next_state = secl_pkg::S_TYPE;
                        end
                    end
                end
                secl_pkg::S_CKSUM: begin
                    // RULE16 sum of all bytes must be 0xFF
                    if (sum != secl_pkg::CKSUM_GOOD && !skip) begin
                        ev_cks = 1'b1;
                        ev_halt = 1'b1;
                    end
                    next_state = secl_pkg::S_IDLE;
                end
                secl_pkg::S_BLANK: begin
                    // a non-blank byte behind a 0xFF type byte is a bad image
                    if (EE_DATA != secl_pkg::BLANK_BYTE) begin
                        ev_cks = 1'b1;
                        ev_halt = 1'b1;
                        next_state = secl_pkg::S_IDLE;
                    // RULE7 blank image, checksum ignored
                    end else if (addr == secl_pkg::BLANK_LAST) begin
                        ev_blank = 1'b1;
                        next_state = secl_pkg::S_IDLE;
                    end
                end
                default: begin
                    next_state = secl_pkg::S_IDLE;
                end
            endcase
            // RULE6 wrap past the last address aborts
            if (addr == secl_pkg::ADDR_LAST
                && next_state != secl_pkg::S_IDLE) begin
                ev_roll = 1'b1;
                ev_halt = 1'b1;
                next_state = secl_pkg::S_IDLE;
            end
        end
        // RULE18 every ending of a load
        ev_done = is_fetch(state) && next_state == secl_pkg::S_IDLE;
        // RULE1 next request only after an answer
        next_ee_req = is_fetch(next_state);
        // RULE20 hold until idle
        next_init_hold = next_state != secl_pkg::S_IDLE;
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            state <= secl_pkg::S_SYNC;
            sync_cnt <= 2'h0;
            addr <= 16'h0000;
            dw <= 16'h0000;
            cnt <= 16'h0000;
            data <= 24'h000000;
            bidx <= 2'h0;
            seq <= 1'b0;
            cksum <= 8'h00;
            slave <= 7'h00;
            reg_wr <= 1'b0;
            reg_addr <= 18'h00000;
            reg_wdata <= 32'h00000000;
            ee_req <= 1'b0;
            init_hold <= 1'b1;
        end else begin
            state <= next_state;
            sync_cnt <= next_sync_cnt;
            addr <= next_addr;
            dw <= next_dw;
            cnt <= next_cnt;
            data <= next_data;
            bidx <= next_bidx;
            seq <= next_seq;
            cksum <= next_cksum;
            slave <= next_slave;
            reg_wr <= next_reg_wr;
            reg_addr <= next_reg_addr;
            reg_wdata <= next_reg_wdata;
            ee_req <= next_ee_req;
            init_hold <= next_init_hold;
        end
    end

    assign EE_REQ = ee_req;
    assign EE_SLAVE_ADDR = slave;
    assign EE_BYTE_ADDR = addr;
    assign REG_WR = reg_wr;
    assign REG_ADDR = reg_addr;
    assign REG_WDATA = reg_wdata;
    assign INIT_HOLD = init_hold;

    ////////////////////////////////////////////////////////////////////
    // apb registers: zero wait states, read data latched in setup
    logic [7:0] presc, next_presc;
    logic next_skip;
    logic [3:0] stat, next_stat;
    logic halt, next_halt;
    logic [31:0] prdata, next_prdata;
    logic pslverr, next_pslverr;
    logic pready;
    logic setup, wr;
    logic [3:0] ev_vec;

    always_comb begin
        setup = PSEL && !PENABLE;
        wr = PSEL && PENABLE && PWRITE && pready && !pslverr;
        next_presc = presc;
        next_skip = skip;
        next_halt = halt;
        next_prdata = prdata;
        next_pslverr = pslverr && PSEL && PENABLE;
        ev_vec = 4'h0;
        ev_vec[secl_pkg::STAT_DONE_BIT] = ev_done;
        ev_vec[secl_pkg::STAT_CKS_BIT] = ev_cks;
        ev_vec[secl_pkg::STAT_ROLL_BIT] = ev_roll;
        ev_vec[secl_pkg::STAT_BLANK_BIT] = ev_blank;
        next_stat = stat;
        if (setup) begin
            next_pslverr = 1'b0;
            case (PADDR)
                secl_pkg::OFS_CTRL: next_prdata = {23'h000000, skip, presc};
                secl_pkg::OFS_STAT: next_prdata = {28'h0000000, stat};
                secl_pkg::OFS_SWITCH_CONTROL_REGISTER: next_prdata = {31'h00000000, halt};
                default: begin
                    next_prdata = 32'h00000000;
                    next_pslverr = 1'b1;
                end
            endcase
        end
        if (wr) begin
            case (PADDR)
                secl_pkg::OFS_CTRL: begin
                    next_presc = PWDATA[7:0];
                    next_skip = PWDATA[secl_pkg::CTRL_SKIP_BIT];
                end
                secl_pkg::OFS_STAT: next_stat = stat & ~PWDATA[3:0];
                secl_pkg::OFS_SWITCH_CONTROL_REGISTER: begin
                    next_halt = PWDATA[secl_pkg::SWITCH_CONTROL_REGISTER_HALT_BIT];
                end
                default: next_stat = stat;
            endcase
        end
        // RULE2 prescaler loaded from slow strap
        if (ev_strap) begin
            next_presc = slow_sync ? secl_pkg::PRESC_SLOW
                                   : secl_pkg::PRESC_FAST;
        end
        // hardware events win over a same-cycle clear
        next_stat = next_stat | ev_vec;
        next_halt = next_halt | ev_halt;
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            presc <= secl_pkg::PRESC_FAST;
            skip <= secl_pkg::SKIP_RESET;
            stat <= secl_pkg::STAT_RESET;
            halt <= secl_pkg::HALT_RESET;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            presc <= next_presc;
            skip <= next_skip;
            stat <= next_stat;
            halt <= next_halt;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
            pready <= 1'b1;
        end
    end

    assign PRDATA = prdata;
    assign PREADY = pready;
    assign PSLVERR = pslverr;
    assign MASTER_CLOCK_PRESCALER = presc;

    ////////////////////////////////////////////////////////////////////
    // checks
    a_strap_prescaler: assert property ( // RULE2
        @(posedge MCLK) disable iff (!RST_B)
        ev_strap |=> presc == (slow_sync ? secl_pkg::PRESC_SLOW
                                         : secl_pkg::PRESC_FAST))
        else $error("prescaler not loaded from slow strap");

    a_mode_idle: assert property ( // RULE3
        @(posedge MCLK) disable iff (!RST_B)
        ev_strap && !uses_ee(mode_sync)
        |=> state == secl_pkg::S_IDLE && !INIT_HOLD && !EE_REQ)
        else $error("loader active in a mode without eeprom");

    a_slave_fixed: assert property ( // RULE4
        @(posedge MCLK) disable iff (!RST_B)
        ev_strap |=> EE_SLAVE_ADDR == {3'h5, $past(eaddr_sync)})
        else $error("eeprom slave address wrong");

    a_first_byte: assert property ( // RULE5
        @(posedge MCLK) disable iff (!RST_B)
        ev_strap && uses_ee(mode_sync)
        |=> EE_REQ && EE_BYTE_ADDR == 16'h0000 && INIT_HOLD)
        else $error("load does not start at byte zero");

    a_wrap_abort: assert property ( // RULE6
        @(posedge MCLK) disable iff (!RST_B)
        EE_REQ && EE_ACK && EE_BYTE_ADDR == 16'hFFFF
        |=> state == secl_pkg::S_IDLE && !EE_REQ ##1 stat[0])
        else $error("address wrap did not end the load");

    a_blank_flag: assert property ( // RULE7
        @(posedge MCLK) disable iff (!RST_B)
        state == secl_pkg::S_BLANK && EE_ACK && EE_DATA == 8'hFF
        && addr == 16'h00FF
        |=> stat[3] && stat[0] && !INIT_HOLD && !halt)
        else $error("blank eeprom not flagged");

    a_write_aligned: assert property ( // RULE12
        @(posedge MCLK) disable iff (!RST_B)
        REG_WR |-> REG_ADDR[1:0] == 2'b00
        && REG_ADDR[17:2] == 16'($past(dw)))
        else $error("register address not dword based");

    a_write_after_four: assert property ( // RULE19
        @(posedge MCLK) disable iff (!RST_B)
        REG_WR |-> $past(state) == secl_pkg::S_DATA
        && $past(bidx) == 2'h3 && $past(EE_ACK))
        else $error("register write before four data bytes");

    a_bad_type: assert property ( // RULE17
        @(posedge MCLK) disable iff (!RST_B)
        state == secl_pkg::S_TYPE && EE_ACK && EE_DATA[7:6] == 2'h2
        && addr != 16'h0000
        |=> stat[1] && halt && state == secl_pkg::S_IDLE)
        else $error("type 0x2 not treated as an error");

    a_cksum_error: assert property ( // RULE16
        @(posedge MCLK) disable iff (!RST_B)
        state == secl_pkg::S_CKSUM && EE_ACK && !skip
        && 8'(cksum + EE_DATA) != 8'hFF
        |=> stat[1] && halt)
        else $error("checksum mismatch not flagged");

    a_done_flag: assert property ( // RULE18
        @(posedge MCLK) disable iff (!RST_B)
        is_fetch(state) ##1 state == secl_pkg::S_IDLE |-> stat[0])
        else $error("load complete flag missing");

endmodule : secl_loader

`default_nettype wire

// *** tb/secl_eeprom_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module secl_eeprom_model (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic req,
    input wire logic [6:0] slave_addr,
    input wire logic [6:0] own_addr,
    input wire logic [15:0] byte_addr,
    input wire logic [3:0] dly,
    output logic ack,
    output logic [7:0] data
);
    logic [7:0] mem [0:65535];
    logic [7:0] last;
    logic [3:0] cnt;

    ////////////////////////////////////////////////////////////////////////
    // sole responder
    // answers only a request aimed at its own strapped address
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ack <= 1'b0;
            cnt <= 4'h0;
            last <= 8'h00;
        end else begin
            if (ack) begin
                last <= data;
            end
            if (!req || slave_addr !== own_addr) begin
                ack <= 1'b0;
                cnt <= 4'h0;
            end else if (cnt >= dly) begin
                ack <= 1'b1;
                cnt <= 4'h0;
            end else begin
                ack <= 1'b0;
                cnt <= cnt + 4'h1;
            end
        end
    end

    // a released line must not keep showing the last byte
    assign data = ack ? mem[byte_addr] : ~last;
endmodule : secl_eeprom_model

`default_nettype wire

// *** tb/secl_loader_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, e, g) begin \
    cmp_count++; \
    if ((e) !== (g)) begin \
        mismatches++; \
        $display("MISMATCH %s expected %h seen %h", nm, e, g); \
    end \
end

module secl_loader_test;
    logic MCLK = 1'b0;
    logic RST_B = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] mode = 4'h0, straps = 4'h0, dly = 4'h0;
    logic pready, pslverr, ee_req, ee_ack, reg_wr, init_hold, err;
    logic req_seen = 1'b0;
    logic [6:0] slave;
    logic [15:0] byte_addr;
    logic [7:0] ee_data, presc;
    logic [17:0] reg_addr;
    logic [31:0] reg_wdata;
    logic [7:0] img[$];
    logic [49:0] exp_q[$], got_q[$];
    int mismatches = 0, cmp_count = 0;

    secl_loader i_secl_loader (.MCLK(MCLK), .RST_B(RST_B), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .MASTER_SLOW_MODE_STRAP(slow), .SWITCH_OPERATING_MODE_STRAP(mode),
        .EEPROM_ADDRESS_STRAPS(straps), .EE_REQ(ee_req), .EE_SLAVE_ADDR(slave),
        .EE_BYTE_ADDR(byte_addr), .EE_ACK(ee_ack), .EE_DATA(ee_data),
        .REG_WR(reg_wr), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .INIT_HOLD(init_hold), .MASTER_CLOCK_PRESCALER(presc));
    secl_eeprom_model i_secl_eeprom_model (.mclk(MCLK), .rst_b(RST_B),
        .req(ee_req), .slave_addr(slave), .own_addr({3'h5, straps}),
        .byte_addr(byte_addr), .dly(dly), .ack(ee_ack), .data(ee_data));

    initial begin
        forever #12.5 MCLK = ~MCLK;
    end
    always @(posedge MCLK) begin
        if (reg_wr === 1'b1) got_q.push_back({reg_addr, reg_wdata});
        if (ee_req === 1'b1) req_seen = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] wd);
        @(posedge MCLK);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge MCLK);
        penable <= 1'b1;
        // the wait ends once pready is high; only the watchdog ends a hung one
        do begin
            @(posedge MCLK);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic add_word(input logic [31:0] d);
        for (int i = 0; i < 4; i++) img.push_back(d[8*i +: 8]);
    endtask : add_word

    task automatic add_single(input logic [15:0] a, input logic [31:0] d);
        img.push_back(8'h00);
        img.push_back(a[7:0]);
        img.push_back(a[15:8]);
        add_word(d);
        exp_q.push_back({a, 2'h0, d});
    endtask : add_single

    task automatic add_seq(input logic [15:0] a, input logic [15:0] n);
        logic [31:0] d;
        img.push_back(8'h40);
        img.push_back(a[7:0]);
        img.push_back(a[15:8]);
        img.push_back(n[7:0]);
        img.push_back(n[15:8]);
        for (int i = 0; i < n; i++) begin
            d = $urandom;
            add_word(d);
            exp_q.push_back({a + 16'(i), 2'h0, d});
        end
    endtask : add_seq

    // bad is added, so a nonzero bad makes the byte sum miss all ones
    task automatic add_done(input logic [7:0] bad);
        logic [7:0] s;
        s = 8'hC0;
        foreach (img[i]) s += img[i];
        img.push_back(8'hC0);
        img.push_back(8'hFF - s + bad);
    endtask : add_done

    task automatic run(input logic [3:0] m, input logic [3:0] d,
            input logic skip, input logic [3:0] st, input logic halt,
            input logic cmp_wr);
        int n;
        logic [7:0] pexp;
        for (int i = 0; i < 65536; i++)
            i_secl_eeprom_model.mem[i] = (i < img.size()) ? img[i] : 8'hFF;
        got_q.delete();
        mode <= m;
        dly <= d;
        slow <= 1'($urandom);
        straps <= 4'($urandom);
        RST_B <= 1'b0;
        repeat (16) @(posedge MCLK);
        req_seen = 1'b0;
        RST_B <= 1'b1;
        pexp = slow ? secl_pkg::PRESC_SLOW : secl_pkg::PRESC_FAST;
        if (skip) apb(1'b1, 8'h00, {23'h0, 1'b1, pexp});
        n = 0;
        while (init_hold !== 1'b0 && n < 70000) begin
            @(posedge MCLK);
            n++;
        end
        `CHECK("init_hold", 1'b0, init_hold)
        `CHECK("req_seen", m[0], req_seen)
        apb(1'b0, 8'h04, 32'h0);
        `CHECK("status", st, rd[3:0])
        apb(1'b0, 8'h08, 32'h0);
        `CHECK("halt", halt, rd[0])
        `CHECK("prescaler", pexp, presc)
        `CHECK("slave", {3'h5, straps}, slave)
        apb(1'b0, 8'h00, 32'h0);
        `CHECK("control", {23'h0, skip, pexp}, rd)
        if (cmp_wr) begin
            `CHECK("writes", exp_q.size(), got_q.size())
            foreach (exp_q[i])
                `CHECK("write", exp_q[i], got_q[i])
        end
        img.delete();
        exp_q.delete();
    endtask : run

    task automatic wrap_up();
        $display("mismatches %0d cmp_count %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (90000) @(posedge MCLK);
        mismatches++;
        wrap_up();
    end

    initial begin
        void'($urandom(71036));
        repeat (3) begin
            add_single(16'($urandom), $urandom);
            add_seq(16'($urandom), 16'($urandom_range(0, 3)));
            add_single(16'hFFFF, $urandom);
            add_done(8'h00);
            run({3'($urandom), 1'b1}, 4'($urandom_range(0, 3)), 0, 4'h1, 0, 1);
        end
        add_single(16'($urandom), $urandom);
        img.push_back(8'h80);
        run({3'($urandom), 1'b1}, 4'h1, 0, 4'h3, 1, 1);
        add_single(16'($urandom), $urandom);
        add_done(8'h01);
        run({3'($urandom), 1'b1}, 4'h0, 0, 4'h3, 1, 1);
        add_single(16'($urandom), $urandom);
        add_done(8'h01);
        run({3'($urandom), 1'b1}, 4'hF, 1, 4'h1, 0, 1);
        run({3'($urandom), 1'b1}, 4'h0, 0, 4'h9, 0, 1);
        // leading 0xFF but a later byte is not: a bad image, not a blank one
        img = '{8'hFF, 8'h5A};
        run({3'($urandom), 1'b1}, 4'h2, 0, 4'h3, 1, 1);
        add_single(16'($urandom), $urandom);
        exp_q.delete();
        run({3'($urandom), 1'b0}, 4'h0, 0, 4'h0, 0, 1);
        img = '{8'h40, 8'h00, 8'h00, 8'hFF, 8'hFF};
        run({3'($urandom), 1'b1}, 4'h0, 0, 4'h5, 1, 0);
        apb(1'b1, 8'h04, 32'h0000_000F);
        apb(1'b0, 8'h04, 32'h0);
        `CHECK("status_clear", 4'h0, rd[3:0])
        apb(1'b0, 8'h0C, 32'h0);
        `CHECK("unmapped", 33'h1_0000_0000, {err, rd})
        wrap_up();
    end
endmodule : secl_loader_test

`default_nettype wire
